/* File: hw/phy_rst_params.svh */
// constants for the transceiver reset and energy-detect block
// assumes a 10 MHz system clock shared by both ends
`ifndef PHY_RST_PARAMS_SVH
`define PHY_RST_PARAMS_SVH

`define CLK_PERIOD_NS 100
// management register offsets
`define BASIC_MODE_CONTROL_ADDR 5'h00
`define ENERGY_DETECT_CONTROL_ADDR 5'h1D
// field positions
`define SOFT_RESET_BIT 15
`define ED_ENABLE_BIT 15
`define ED_LOW_POWER_BIT 8
`define ED_WAKE_BIT 9
// reset values and timeout read data
`define BASIC_MODE_CONTROL_RESET 16'h0000
`define ENERGY_DETECT_CONTROL_RESET 16'h0000
`define TIMEOUT_READ_DATA 16'hFFFF
// software reset takes about 1 us
`define SOFT_RESET_NS 1000
`define SOFT_RESET_CYCLES (`SOFT_RESET_NS / `CLK_PERIOD_NS)
// hardware reset pulse, least time
`define HW_RESET_MIN_NS 1000
`define HW_RESET_MIN_CYCLES ((`HW_RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// quiet time on the management port after a reset, least time
`define MGMT_WAIT_NS 3000
`define MGMT_WAIT_CYCLES ((`MGMT_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// internal power-on reset length
`define POR_CYCLES 10
// energy-detect timing defaults and the host ack timeout
`define ED_IDLE_CYCLES 200
`define ED_PULSE_PERIOD_CYCLES 100
`define ED_PULSE_LEN_CYCLES 2
`define ED_WAKE_CYCLES 20
`define ACK_TIMEOUT_CYCLES 8

`endif

/* File: hw/phy_rst_pkg.sv */
// types shared by both ends of the transceiver reset link
// assumes phy_rst_params.svh carries the numbers
package phy_rst_pkg;

  typedef enum logic [2:0] {
    rs_hard = 3'b001,
    rs_run  = 3'b010,
    rs_soft = 3'b100
  } rst_state_t;

  typedef enum logic [2:0] {
    ed_active = 3'b001,
    ed_low    = 3'b010,
    ed_wake   = 3'b100
  } ed_state_t;

  typedef enum logic [3:0] {
    h_idle    = 4'b0001,
    h_wait    = 4'b0010,
    h_reset   = 4'b0100,
    h_holdoff = 4'b1000
  } host_state_t;

  typedef logic [4:0] mgmt_addr_t;
  typedef logic [15:0] mgmt_data_t;

endpackage

/* File: hw/phy_link_if.sv */
// link between management controller and transceiver
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface phy_link_if;
  logic reset_n;
  logic mgmt_req;
  logic mgmt_we;
  phy_rst_pkg::mgmt_addr_t mgmt_addr;
  phy_rst_pkg::mgmt_data_t mgmt_wdata;
  logic mgmt_ack;
  phy_rst_pkg::mgmt_data_t mgmt_rdata;

  modport dev (
    input reset_n,
    input mgmt_req,
    input mgmt_we,
    input mgmt_addr,
    input mgmt_wdata,
    output mgmt_ack,
    output mgmt_rdata
  );

  modport host (
    output reset_n,
    output mgmt_req,
    output mgmt_we,
    output mgmt_addr,
    output mgmt_wdata,
    input mgmt_ack,
    input mgmt_rdata
  );
endinterface

/* File: hw/phy_reset_and_energy_detect.sv */
// transceiver end: reset sequencing, management registers, energy detect
// assumes host logic on the same clock drives the link; line and straps are pins
`timescale 1ns/1ps
`include "phy_rst_params.svh"

// Notes on behaviour
// R1: idle enabled line keeps device in low power
// R2: line activity wakes device through power-up
// R3: low power periodically pulses transmitter enable
// R4: energy detect configured at register 0x1D
// R5: internal power-on reset needs no pin
// R6: host holds reset pin low one microsecond
// R7: pin reset restores defaults, recaptures straps
// R8: control bit 15 starts one microsecond reset
// R9: software reset keeps latched straps
// R10: host waits three microseconds after reset
// R11: reference clock 25 or 50 MHz; the model clocks both ends at 10 MHz
// R12: software reset bit clears itself
module phy_reset_and_energy_detect #(
  parameter int STRAP_W = 4,
  parameter logic [15:0] ED_IDLE = 16'(`ED_IDLE_CYCLES),
  parameter logic [15:0] ED_PERIOD = 16'(`ED_PULSE_PERIOD_CYCLES),
  parameter logic [15:0] ED_PULSE = 16'(`ED_PULSE_LEN_CYCLES),
  parameter logic [15:0] ED_WAKE = 16'(`ED_WAKE_CYCLES)
) (
  input wire logic clk,
  input wire logic rst,
  phy_link_if.dev lnk,
  input wire logic line_activity,
  input wire logic [STRAP_W-1:0] strap_in,
  output logic low_power,
  output logic ed_tx_en,
  output logic [STRAP_W-1:0] strap_latched,
  output logic in_reset
);
  import phy_rst_pkg::*;

  // ************************************************
  // pin synchronisers
  // ************************************************
  logic [2:0] act_s_r, act_s_nxt;
  logic act_r, act_nxt;
  logic [STRAP_W-1:0] st_s1_r, st_s2_r, st_s3_r;
  logic [STRAP_W-1:0] st_s1_nxt, st_s2_nxt, st_s3_nxt;
  logic [STRAP_W-1:0] st_r, st_nxt;

  always_comb begin
    act_s_nxt = {act_s_r[1:0], line_activity};
    act_nxt = act_r;
    // a change counts only once the second and third stages agree
    if (act_s_r[1] == act_s_r[2]) begin
      act_nxt = act_s_r[2];
    end
    st_s1_nxt = strap_in;
    st_s2_nxt = st_s1_r;
    st_s3_nxt = st_s2_r;
    st_nxt = st_r;
    if (st_s2_r == st_s3_r) begin
      st_nxt = st_s3_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      act_s_r <= 3'h0;
      act_r <= 1'b0;
      st_s1_r <= '0;
      st_s2_r <= '0;
      st_s3_r <= '0;
      st_r <= '0;
    end else begin
      act_s_r <= act_s_nxt;
      act_r <= act_nxt;
      st_s1_r <= st_s1_nxt;
      st_s2_r <= st_s2_nxt;
      st_s3_r <= st_s3_nxt;
      st_r <= st_nxt;
    end
  end

  // ************************************************
  // reset sequencer
  // ************************************************
  rst_state_t rs_r, rs_nxt;
  logic [7:0] rcnt_r, rcnt_nxt;
  logic [STRAP_W-1:0] strap_r, strap_nxt;
  logic in_reset_r, in_reset_nxt;
  logic soft_start;

  function automatic logic addr_is(input mgmt_addr_t a, input mgmt_addr_t ref_a);
    addr_is = (a == ref_a);
  endfunction

  assign soft_start = lnk.mgmt_req && lnk.mgmt_we && lnk.mgmt_wdata[`SOFT_RESET_BIT]
                      && addr_is(lnk.mgmt_addr, `BASIC_MODE_CONTROL_ADDR);

  always_comb begin
    rs_nxt = rs_r;
    rcnt_nxt = rcnt_r;
    strap_nxt = strap_r;
    case (rs_r)
      rs_hard: begin
        if (!lnk.reset_n) begin
          rcnt_nxt = 8'(`POR_CYCLES); // R7
        end else if (rcnt_r == 8'h00) begin
          rs_nxt = rs_run;
          strap_nxt = st_r; // R7
        end else begin
          rcnt_nxt = rcnt_r - 8'h01; // R5
        end
      end
      rs_run: begin
        if (!lnk.reset_n) begin
          rs_nxt = rs_hard;
          rcnt_nxt = 8'(`POR_CYCLES);
        end else if (soft_start) begin
          rs_nxt = rs_soft; // R8
          rcnt_nxt = 8'(`SOFT_RESET_CYCLES - 1);
        end
      end
      rs_soft: begin
        if (!lnk.reset_n) begin
          rs_nxt = rs_hard;
          rcnt_nxt = 8'(`POR_CYCLES);
        end else if (rcnt_r == 8'h00) begin
          rs_nxt = rs_run; // R12
        end else begin
          rcnt_nxt = rcnt_r - 8'h01; // R8
        end
      end
      default: begin
        rs_nxt = rs_hard;
        rcnt_nxt = 8'(`POR_CYCLES);
      end
    endcase
    in_reset_nxt = (rs_nxt != rs_run);
  end

  // straps are left alone by the soft path so a driver reset keeps the mode
  always_ff @(posedge clk) begin
    if (rst) begin
      rs_r <= rs_hard; // R5
      rcnt_r <= 8'(`POR_CYCLES);
      strap_r <= '0;
      in_reset_r <= 1'b1;
    end else begin
      rs_r <= rs_nxt;
      rcnt_r <= rcnt_nxt;
      strap_r <= strap_nxt; // R9
      in_reset_r <= in_reset_nxt;
    end
  end

  // ************************************************
  // management registers
  // ************************************************
  logic [15:0] bmc_r, bmc_nxt;
  logic [15:0] edc_r, edc_nxt;
  logic ack_r, ack_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  ed_state_t ed_r, ed_nxt;
  logic ed_wake_seen_r, ed_wake_seen_nxt;

  function automatic logic [15:0] reg_read(input mgmt_addr_t a, input logic [15:0] bmc,
                                           input logic [15:0] edc, input logic lp, input logic wk);
    logic [15:0] v;
    v = 16'h0000;
    if (addr_is(a, `BASIC_MODE_CONTROL_ADDR)) begin
      v = bmc;
      v[`SOFT_RESET_BIT] = 1'b0; // R12
    end else if (addr_is(a, `ENERGY_DETECT_CONTROL_ADDR)) begin
      v = edc;
      v[`ED_LOW_POWER_BIT] = lp;
      v[`ED_WAKE_BIT] = wk;
    end
    reg_read = v;
  endfunction

  always_comb begin
    bmc_nxt = bmc_r;
    edc_nxt = edc_r;
    ed_wake_seen_nxt = ed_wake_seen_r;
    ack_nxt = 1'b0;
    rdata_nxt = rdata_r;
    if (rs_r != rs_run) begin
      // both reset kinds return every register to its default
      bmc_nxt = `BASIC_MODE_CONTROL_RESET; // R7
      edc_nxt = `ENERGY_DETECT_CONTROL_RESET; // R9
      ed_wake_seen_nxt = 1'b0;
    end else begin
      if (ed_r == ed_low && ed_nxt == ed_wake) begin
        ed_wake_seen_nxt = 1'b1;
      end
      if (lnk.mgmt_req) begin
        ack_nxt = 1'b1;
        rdata_nxt = reg_read(lnk.mgmt_addr, bmc_r, edc_r, ed_r == ed_low, ed_wake_seen_r);
        if (lnk.mgmt_we) begin
          if (addr_is(lnk.mgmt_addr, `BASIC_MODE_CONTROL_ADDR)) begin
            bmc_nxt = lnk.mgmt_wdata;
          end else if (addr_is(lnk.mgmt_addr, `ENERGY_DETECT_CONTROL_ADDR)) begin
            edc_nxt = lnk.mgmt_wdata; // R4
          end
        end else if (addr_is(lnk.mgmt_addr, `ENERGY_DETECT_CONTROL_ADDR)) begin
          // wake flag clears on read; a wake in the same cycle still sets it
          ed_wake_seen_nxt = (ed_r == ed_low && ed_nxt == ed_wake);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bmc_r <= `BASIC_MODE_CONTROL_RESET;
      edc_r <= `ENERGY_DETECT_CONTROL_RESET;
      ed_wake_seen_r <= 1'b0;
      ack_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      bmc_r <= bmc_nxt;
      edc_r <= edc_nxt;
      ed_wake_seen_r <= ed_wake_seen_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ************************************************
  // energy detect
  // ************************************************
  logic [15:0] ecnt_r, ecnt_nxt;
  logic lp_r, lp_nxt;
  logic tx_r, tx_nxt;
  logic ed_en;

  assign ed_en = edc_r[`ED_ENABLE_BIT];

  always_comb begin
    ed_nxt = ed_r;
    ecnt_nxt = ecnt_r;
    if (rs_r != rs_run) begin
      ed_nxt = ed_active;
      ecnt_nxt = ED_IDLE;
    end else begin
      case (ed_r)
        ed_active: begin
          if (!ed_en || act_r) begin
            ecnt_nxt = ED_IDLE;
          end else if (ecnt_r == 16'h0000) begin
            ed_nxt = ed_low; // R1
            ecnt_nxt = ED_PERIOD;
          end else begin
            ecnt_nxt = ecnt_r - 16'h0001;
          end
        end
        ed_low: begin
          if (act_r) begin
            ed_nxt = ed_wake; // R2
            ecnt_nxt = ED_WAKE;
          end else if (!ed_en) begin
            ed_nxt = ed_active;
            ecnt_nxt = ED_IDLE;
          end else if (ecnt_r == 16'h0000) begin
            ecnt_nxt = ED_PERIOD; // R3
          end else begin
            ecnt_nxt = ecnt_r - 16'h0001; // R1
          end
        end
        ed_wake: begin
          if (ecnt_r == 16'h0000) begin
            ed_nxt = ed_active; // R2
            ecnt_nxt = ED_IDLE;
          end else begin
            ecnt_nxt = ecnt_r - 16'h0001;
          end
        end
        default: begin
          ed_nxt = ed_active;
          ecnt_nxt = ED_IDLE;
        end
      endcase
    end
    lp_nxt = (ed_nxt == ed_low);
    // transmitter is switched on only for the tail of each period
    tx_nxt = (ed_nxt == ed_low) && (ecnt_nxt < ED_PULSE); // R3
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ed_r <= ed_active;
      ecnt_r <= ED_IDLE;
      lp_r <= 1'b0;
      tx_r <= 1'b0;
    end else begin
      ed_r <= ed_nxt;
      ecnt_r <= ecnt_nxt;
      lp_r <= lp_nxt;
      tx_r <= tx_nxt;
    end
  end

  assign lnk.mgmt_ack = ack_r;
  assign lnk.mgmt_rdata = rdata_r;
  assign low_power = lp_r;
  assign ed_tx_en = tx_r;
  assign strap_latched = strap_r;
  assign in_reset = in_reset_r;

endmodule

/* File: hw/phy_mgmt_host.sv */
// management controller end: drives the reset pin and register requests
// assumes the transceiver runs on the same clock
`timescale 1ns/1ps
`include "phy_rst_params.svh"

module phy_mgmt_host (
  input wire logic clk,
  input wire logic rst,
  phy_link_if.host lnk,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire phy_rst_pkg::mgmt_addr_t cmd_addr,
  input wire phy_rst_pkg::mgmt_data_t cmd_wdata,
  input wire logic hw_reset_req,
  output logic cmd_ready,
  output logic rsp_valid,
  output phy_rst_pkg::mgmt_data_t rsp_data,
  output logic busy
);
  import phy_rst_pkg::*;

  // ************************************************
  // request sequencer
  // ************************************************
  host_state_t hs_r, hs_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic soft_r, soft_nxt;
  logic req_r, req_nxt;
  logic we_r, we_nxt;
  mgmt_addr_t addr_r, addr_nxt;
  mgmt_data_t wdata_r, wdata_nxt;
  logic rstn_r, rstn_nxt;
  logic ready_r, ready_nxt;
  logic rsp_r, rsp_nxt;
  mgmt_data_t rdat_r, rdat_nxt;
  logic busy_r, busy_nxt;

  always_comb begin
    hs_nxt = hs_r;
    cnt_nxt = cnt_r;
    soft_nxt = soft_r;
    req_nxt = 1'b0;
    we_nxt = we_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rstn_nxt = 1'b1;
    rsp_nxt = 1'b0;
    rdat_nxt = rdat_r;
    case (hs_r)
      h_idle: begin
        if (hw_reset_req) begin
          hs_nxt = h_reset;
          rstn_nxt = 1'b0;
          cnt_nxt = 8'(`HW_RESET_MIN_CYCLES - 1); // R6
        end else if (cmd_valid && ready_r) begin
          hs_nxt = h_wait;
          req_nxt = 1'b1;
          we_nxt = cmd_write;
          addr_nxt = cmd_addr;
          wdata_nxt = cmd_wdata;
          soft_nxt = cmd_write && cmd_wdata[`SOFT_RESET_BIT] && (cmd_addr == `BASIC_MODE_CONTROL_ADDR);
          cnt_nxt = 8'(`ACK_TIMEOUT_CYCLES);
        end
      end
      h_wait: begin
        if (lnk.mgmt_ack || cnt_r == 8'h00) begin
          rsp_nxt = 1'b1;
          // a missing answer reads like an undriven data line
          rdat_nxt = lnk.mgmt_ack ? lnk.mgmt_rdata : `TIMEOUT_READ_DATA;
          if (soft_r) begin
            hs_nxt = h_holdoff; // R10
            cnt_nxt = 8'(`MGMT_WAIT_CYCLES - 1);
          end else begin
            hs_nxt = h_idle;
          end
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      h_reset: begin
        if (cnt_r == 8'h00) begin
          hs_nxt = h_holdoff;
          cnt_nxt = 8'(`MGMT_WAIT_CYCLES - 1);
        end else begin
          rstn_nxt = 1'b0; // R6
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      h_holdoff: begin
        if (cnt_r == 8'h00) begin
          hs_nxt = h_idle;
        end else begin
          cnt_nxt = cnt_r - 8'h01; // R10
        end
      end
      default: begin
        hs_nxt = h_idle;
      end
    endcase
    ready_nxt = (hs_nxt == h_idle) && !hw_reset_req;
    busy_nxt = (hs_nxt != h_idle);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hs_r <= h_idle;
      cnt_r <= 8'h00;
      soft_r <= 1'b0;
      req_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= 5'h00;
      wdata_r <= 16'h0000;
      rstn_r <= 1'b1;
      ready_r <= 1'b0;
      rsp_r <= 1'b0;
      rdat_r <= 16'h0000;
      busy_r <= 1'b0;
    end else begin
      hs_r <= hs_nxt;
      cnt_r <= cnt_nxt;
      soft_r <= soft_nxt;
      req_r <= req_nxt;
      we_r <= we_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rstn_r <= rstn_nxt;
      ready_r <= ready_nxt;
      rsp_r <= rsp_nxt;
      rdat_r <= rdat_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign lnk.reset_n = rstn_r;
  assign lnk.mgmt_req = req_r;
  assign lnk.mgmt_we = we_r;
  assign lnk.mgmt_addr = addr_r;
  assign lnk.mgmt_wdata = wdata_r;
  assign cmd_ready = ready_r;
  assign rsp_valid = rsp_r;
  assign rsp_data = rdat_r;
  assign busy = busy_r;

endmodule

/* File: bench/phy_link_checker.sv */
// checker for the reset and management link between the two ends
// assumes one clock, sync active-high rst, instantiated beside phy_link_if
`timescale 1ns/1ps
`include "phy_rst_params.svh"
module phy_link_checker (
  input logic clk,
  input logic rst,
  input logic reset_n,
  input logic mgmt_req,
  input logic mgmt_we,
  input phy_rst_pkg::mgmt_addr_t mgmt_addr,
  input phy_rst_pkg::mgmt_data_t mgmt_wdata,
  input logic mgmt_ack,
  input phy_rst_pkg::mgmt_data_t mgmt_rdata
);
  import phy_rst_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************
  // helper state
  // ****************
  logic [5:0] quiet_r, quiet_nxt;
  logic [3:0] low_r, low_nxt;
  logic en_r, en_nxt;
  logic soft_wr;
  assign soft_wr = mgmt_req && mgmt_we && mgmt_addr == 5'h00 && mgmt_wdata[15];
  always_comb begin
    quiet_nxt = (quiet_r != 6'h00) ? quiet_r - 6'h01 : 6'h00;
    // quiet window counted from the request, a little shorter than the host keeps
    if (soft_wr || !reset_n) begin
      quiet_nxt = 6'(`MGMT_WAIT_CYCLES);
    end
    low_nxt = reset_n ? 4'h0 : ((low_r == 4'hF) ? low_r : low_r + 4'h1);
    en_nxt = en_r;
    if (mgmt_req && mgmt_we && mgmt_addr == 5'h1D) begin
      en_nxt = mgmt_wdata[15];
    end
    if (soft_wr || !reset_n) begin
      en_nxt = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      quiet_r <= 6'h00;
      low_r <= 4'h0;
      en_r <= 1'b0;
    end else begin
      quiet_r <= quiet_nxt;
      low_r <= low_nxt;
      en_r <= en_nxt;
    end
  end
  // ****************
  // properties
  // ****************
  sequence s_rd(a);
    mgmt_req && !mgmt_we && mgmt_addr == a ##1 mgmt_ack;
  endsequence
  sequence s_rd_unmapped;
    mgmt_req && !mgmt_we && mgmt_addr != 5'h00 && mgmt_addr != 5'h1D ##1 mgmt_ack;
  endsequence
  property p_req_ack; mgmt_req |=> mgmt_ack; endproperty
  property p_ack_cause; mgmt_ack |-> $past(mgmt_req); endproperty
  property p_selfclr; s_rd(5'h00) |-> mgmt_rdata[15] == 1'b0; endproperty
  property p_quiet; quiet_r != 6'h00 |-> !mgmt_req; endproperty
  property p_pin_width; $rose(reset_n) |-> low_r >= 4'(`HW_RESET_MIN_CYCLES); endproperty
  property p_pin_mute; !reset_n |=> !mgmt_ack; endproperty
  property p_en_bit; s_rd(5'h1D) |-> mgmt_rdata[15] == en_r; endproperty
  property p_unmapped; s_rd_unmapped |-> mgmt_rdata == 16'h0000; endproperty
  a_req_ack: assert property (p_req_ack) else $error("request not answered next cycle");
  a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
  a_selfclr: assert property (p_selfclr) else $error("soft reset bit reads one");
  a_quiet: assert property (p_quiet) else $error("request inside quiet window");
  a_pin_width: assert property (p_pin_width) else $error("reset pin pulse too short");
  a_pin_mute: assert property (p_pin_mute) else $error("answer during pin reset");
  a_en_bit: assert property (p_en_bit) else $error("enable bit not at default or written value");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

/* File: bench/tb_phy_reset_and_energy_detect.sv */
// self-checking bench: host end and transceiver end joined by phy_link_if
// assumes the design package, interface and header are compiled first
`timescale 1ns/1ps
module tb_phy_reset_and_energy_detect;
  import phy_rst_pkg::*;
  logic clk, rst, line_activity, cmd_valid, cmd_write, hw_reset_req;
  logic low_power, ed_tx_en, in_reset, cmd_ready, rsp_valid, busy;
  logic [3:0] strap_in, strap_latched;
  mgmt_addr_t cmd_addr;
  mgmt_data_t cmd_wdata, rsp_data, rd;
  int error_cnt, n_compared;
  phy_link_if lnk();
  // short energy-detect counts keep the run brief
  phy_reset_and_energy_detect #(.STRAP_W(4), .ED_IDLE(16'h0005), .ED_PERIOD(16'h0008), .ED_PULSE(16'h0002),
    .ED_WAKE(16'h0003)) phy_reset_and_energy_detect_inst (.clk(clk), .rst(rst), .lnk(lnk),
    .line_activity(line_activity), .strap_in(strap_in), .low_power(low_power), .ed_tx_en(ed_tx_en),
    .strap_latched(strap_latched), .in_reset(in_reset));
  phy_mgmt_host phy_mgmt_host_inst (.clk(clk), .rst(rst), .lnk(lnk), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .hw_reset_req(hw_reset_req),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy(busy));
  phy_link_checker phy_link_checker_inst (.clk(clk), .rst(rst), .reset_n(lnk.reset_n),
    .mgmt_req(lnk.mgmt_req), .mgmt_we(lnk.mgmt_we), .mgmt_addr(lnk.mgmt_addr), .mgmt_wdata(lnk.mgmt_wdata),
    .mgmt_ack(lnk.mgmt_ack), .mgmt_rdata(lnk.mgmt_rdata));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ****************
  // tasks
  // ****************
  task automatic conclude();
    if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask
  // one command through the host; valid held until the edge that sees ready
  task automatic xfer(input logic we, input mgmt_addr_t a, input mgmt_data_t d, output mgmt_data_t q);
    int n;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_write = we;
    cmd_addr = a;
    cmd_wdata = d;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("response", 16'h0001, {15'h0000, rsp_valid});
    q = rsp_data;
  endtask
  // bounded wait for a status output to reach a level
  task automatic await(input string nm, input int which, input logic lvl, input int lim);
    int n;
    logic v;
    n = 0;
    do begin
      @(negedge clk);
      v = which == 0 ? low_power : which == 1 ? ed_tx_en : which == 2 ? in_reset : busy;
      n++;
    end while (v !== lvl && n < lim);
    chk(nm, {15'h0000, lvl}, {15'h0000, v});
  endtask
  // ****************
  // tests
  // ****************
  initial begin
    error_cnt = 0;
    n_compared = 0;
    rst = 1'b1;
    line_activity = 1'b1;
    strap_in = 4'h5;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 5'h00;
    cmd_wdata = 16'h0000;
    hw_reset_req = 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    await("in_reset", 2, 1'b0, 40);
    chk("strap", 16'h0005, {12'h000, strap_latched});
    xfer(1'b0, 5'h00, 16'h0000, rd);
    chk("basic_mode_control", 16'h0000, rd);
    xfer(1'b0, 5'h1D, 16'h0000, rd);
    chk("energy_detect_control", 16'h0000, rd);
    xfer(1'b0, 5'h05, 16'h0000, rd);
    chk("unmapped", 16'h0000, rd);
    line_activity = 1'b0;
    repeat (20) @(negedge clk);
    chk("low_power disabled", 16'h0000, {15'h0000, low_power});
    xfer(1'b1, 5'h1D, 16'h8000, rd);
    await("low_power", 0, 1'b1, 40);
    await("ed pulse", 1, 1'b1, 30);
    await("ed pulse end", 1, 1'b0, 5);
    xfer(1'b0, 5'h1D, 16'h0000, rd);
    chk("low state", 16'h8100, rd);
    line_activity = 1'b1;
    await("wake", 0, 1'b0, 20);
    repeat (10) @(negedge clk);
    xfer(1'b0, 5'h1D, 16'h0000, rd);
    chk("wake seen", 16'h8200, rd);
    xfer(1'b0, 5'h1D, 16'h0000, rd);
    chk("wake cleared", 16'h8000, rd);
    // straps move before the soft reset: they must not be taken now
    strap_in = 4'hA;
    xfer(1'b1, 5'h00, 16'h8000, rd);
    chk("soft running", 16'h0001, {15'h0000, in_reset});
    await("soft end", 2, 1'b0, 12);
    chk("strap kept", 16'h0005, {12'h000, strap_latched});
    xfer(1'b0, 5'h00, 16'h0000, rd);
    chk("self clear", 16'h0000, rd);
    xfer(1'b0, 5'h1D, 16'h0000, rd);
    chk("soft default", 16'h0000, rd);
    xfer(1'b1, 5'h1D, 16'h8000, rd);
    hw_reset_req = 1'b1;
    await("pin start", 3, 1'b1, 10);
    hw_reset_req = 1'b0;
    await("pin done", 3, 1'b0, 80);
    chk("strap relatched", 16'h000A, {12'h000, strap_latched});
    xfer(1'b0, 5'h1D, 16'h0000, rd);
    chk("pin default", 16'h0000, rd);
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end
endmodule
